/* File: leac_core.sv */
`timescale 1ns/100ps
`default_nettype none
// Function
// - criteria bit picks loss pulse count
// - line loss after N low intervals
// - threshold field meaning depends on monitor mode
// - tx loss declared low, cleared by pulse
// - tx loss window 16, 32, 64 pulses
// - excess zeros follows ANSI or FCC
// - violation on next mark, then bit clears
// - rising error insert flips one bit
// - counter source selects counted events
// - counter mode manual or one second
// - manual rising update latches count
// - transmit alarm sends ones, not in loopback
// - receive alarm on system/line loss
// - transmit alarm on system/line loss
module leac_core
    import leac_pkg::*;
#(
    parameter int SEC_CYCLES = LEAC_SEC_CYC
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,

    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,

    // line side sampled indications (one per pulse interval strobe)
    input  wire logic        pulse_tick,
    input  wire logic        rx_below_thr,
    input  wire logic        tx_below_thr,
    input  wire logic        monitor_mode,
    input  wire logic        remote_loopback,
    input  wire logic        system_loss_of_signal,

    // error event inputs
    input  wire logic        line_violation_event,
    input  wire logic        line_excess_zeros_event,
    input  wire logic        system_violation_event,
    input  wire logic        system_excess_zeros_event,
    input  wire logic        pattern_error_event,

    // transmit stream in and out
    input  wire logic        tx_mark,
    input  wire logic        tx_data_pos,
    input  wire logic        tx_data_neg,
    input  wire logic        pattern_bit,
    input  wire logic        rx_data_in,
    output logic             tx_line_tip_out,
    output logic             tx_line_ring_out,
    output logic             pattern_out,
    output logic             rx_data_out,
    output logic             line_loss_of_signal,
    output logic             transmit_loss_of_signal,
    output logic [2:0]       line_loss_threshold,
    output logic [1:0]       tx_loss_threshold,
    output logic             excess_zeros_definition,
    output logic             threshold_reserved
);
    initial begin
        if (SEC_CYCLES < 2) $error("SEC_CYCLES too small");
    end

    // all state in one struct, next value built combinationally
    leac_state_t q, d;
    logic        wr_now;
    logic        ev_cnt;
    logic [10:0] n_need;
    logic [6:0]  t_need;
    logic [2:0]  csrc;
    logic        rx_ais, tx_ais;
    logic [7:0]  wb;
    logic [7:0]  rd;
    logic        upd_rise;
    logic        sec_tick;

    // ==========================================================
    // bus decode and combinational next state
    assign wb = hwdata[7:0];
    assign csrc = q.errc[LEAC_B_CSRC +: 3];
    always_comb begin
        d        = q;
        wr_now   = q.dph && q.dwr;
        // criteria bit picks the consecutive interval count
        n_need   = q.loss_cfg[LEAC_B_CRIT] ? 11'(LEAC_N_I431) : 11'(LEAC_N_T1231);
        case (q.loss_cfg[1:0])
            2'b00:   t_need = 7'(LEAC_TXP_16);
            2'b01:   t_need = 7'(LEAC_TXP_32);
            default: t_need = 7'(LEAC_TXP_64);
        endcase

        // event picked by the source field
        case (csrc)
            3'h1:    ev_cnt = line_violation_event;
            3'h2:    ev_cnt = line_excess_zeros_event;
            3'h3:    ev_cnt = line_violation_event | line_excess_zeros_event;
            3'h4:    ev_cnt = system_violation_event;
            3'h5:    ev_cnt = system_excess_zeros_event;
            3'h6:    ev_cnt = system_violation_event | system_excess_zeros_event;
            3'h7:    ev_cnt = pattern_error_event;
            default: ev_cnt = 1'b0;
        endcase

        // address phase capture
        d.dph = hsel && hready && htrans[1];
        if (hsel && hready && htrans[1]) begin
            d.dwr  = hwrite;
            d.didx = haddr[13:2];
        end

        // line and tx loss counters over pulse intervals
        if (pulse_tick) begin
            if (rx_below_thr) begin
                if (q.lrun < n_need) d.lrun = q.lrun + 11'h001;
                if (q.lrun + 11'h001 >= n_need) d.line_los = 1'b1;
            end else begin
                d.lrun     = 11'h000;
                d.line_los = 1'b0;
            end
            if (tx_below_thr) begin
                if (q.trun < t_need) d.trun = q.trun + 7'h01;
                if (q.trun + 7'h01 >= t_need) d.tx_los = 1'b1;
            end else begin
                d.trun   = 7'h00;
                d.tx_los = 1'b0;
            end
        end

        // error counter and latch
        if (ev_cnt && q.err_cnt != 16'hffff) d.err_cnt = q.err_cnt + 16'h0001;
        sec_tick = q.sec_cnt >= 32'(SEC_CYCLES - 1);
        d.sec_cnt = sec_tick ? 32'h0 : q.sec_cnt + 32'h1;
        upd_rise = q.errc[LEAC_B_CUPD] && !q.upd_prev;
        d.upd_prev = q.errc[LEAC_B_CUPD];
        if ((q.errc[LEAC_B_CMODE] && sec_tick) ||
            (!q.errc[LEAC_B_CMODE] && upd_rise)) begin
            d.err_lat = ev_cnt ? q.err_cnt + 16'h0001 : q.err_cnt;
            d.err_cnt = 16'h0000;
            d.stat[4] = 1'b1;
        end

        // single bit error on rising insert bit
        d.eins_prev = q.errc[LEAC_B_EINS];
        if (q.errc[LEAC_B_EINS] && !q.eins_prev) d.eins_pend = 1'b1;
        d.pat_out = pattern_bit;
        if (pulse_tick && q.eins_pend) begin
            d.pat_out   = ~pattern_bit;
            d.eins_pend = 1'b0;
            d.errc[LEAC_B_EINS] = 1'b0;
            d.stat[3] = 1'b1;
        end

        // transmit line: forced ones, violation insert, or data
        tx_ais = (q.alarm[LEAC_B_TRANSMIT_ALARM_FORCE] && !remote_loopback) ||
                 (q.alarm[1] && system_loss_of_signal) ||
                 (q.alarm[0] && q.line_los);
        if (pulse_tick) begin
            if (tx_ais) begin
                // all ones alternate polarity like a normal mark stream
                d.tx_tip   = !q.last_pol;
                d.tx_ring  = q.last_pol;
                d.last_pol = !q.last_pol;
            end else if (tx_mark && q.errc[LEAC_B_VINS]) begin
                // repeat last polarity to form the violation
                d.tx_tip   = q.last_pol;
                d.tx_ring  = !q.last_pol;
                d.errc[LEAC_B_VINS] = 1'b0;
                d.stat[2] = 1'b1;
            end else begin
                d.tx_tip  = tx_data_pos;
                d.tx_ring = tx_data_neg;
                if (tx_data_pos) d.last_pol = 1'b1;
                if (tx_data_neg) d.last_pol = 1'b0;
            end
        end

        // receive data, replaced by ones while enabled loss stands
        rx_ais = (q.alarm[3] && system_loss_of_signal) ||
                 (q.alarm[2] && q.line_los);
        d.rx_data = rx_ais ? 1'b1 : rx_data_in;

        // status events
        if (d.line_los && !q.line_los) d.stat[0] = 1'b1;
        if (d.tx_los && !q.tx_los) d.stat[1] = 1'b1;

        // register writes; hardware sets win over clears, except on a status bit that was already set
        if (wr_now) begin
            case (q.didx)
                LEAC_IDX_LOSS:  d.loss_cfg = wb;
                LEAC_IDX_ERRC:  begin
                    d.errc = wb;
                    if (q.errc[LEAC_B_VINS] && !d.errc[LEAC_B_VINS] && !wb[LEAC_B_VINS])
                        d.errc[LEAC_B_VINS] = 1'b0;
                end
                LEAC_IDX_ALARM: d.alarm = {3'h0, wb[4:0]};
                LEAC_IDX_IEN:   d.ien = wb[4:0];
                LEAC_IDX_ICLR:  d.stat = q.stat & ~wb[4:0] | (d.stat & ~q.stat);
                default:        ;
            endcase
        end
    end

    // ==========================================================
    // read mux
    always_comb begin
        case (q.didx)
            LEAC_IDX_LOSS:  rd = q.loss_cfg;
            LEAC_IDX_ERRC:  rd = q.errc;
            LEAC_IDX_ALARM: rd = q.alarm;
            LEAC_IDX_STAT:  rd = {3'h0, q.stat};
            LEAC_IDX_IEN:   rd = {3'h0, q.ien};
            LEAC_IDX_CNTH:  rd = q.err_lat[15:8];
            LEAC_IDX_CNTL:  rd = q.err_lat[7:0];
            LEAC_IDX_LSTAT: rd = {6'h00, q.tx_los, q.line_los};
            default:        rd = 8'h00;
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q          <= '0;
            q.loss_cfg <= LEAC_LOSS_RST;
            q.errc     <= LEAC_ERRC_RST;
            q.alarm    <= LEAC_ALARM_RST;
        end else begin
            q <= d;
        end
    end

    // outputs
    assign hrdata    = (q.dph && !q.dwr) ? {24'h0, rd} : 32'h0;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(q.stat & q.ien);
    assign tx_line_tip_out         = q.tx_tip;
    assign tx_line_ring_out        = q.tx_ring;
    assign pattern_out             = q.pat_out;
    assign rx_data_out             = q.rx_data;
    assign line_loss_of_signal     = q.line_los;
    assign transmit_loss_of_signal = q.tx_los;
    assign line_loss_threshold     = q.loss_cfg[6:4];
    assign tx_loss_threshold       = q.loss_cfg[3:2];
    assign excess_zeros_definition = q.errc[LEAC_B_EXZDEF];
    // upper codes have no monitor-mode meaning
    assign threshold_reserved      = monitor_mode && q.loss_cfg[6];

    // ==========================================================
    // assertions, all on the bus clock
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // an insert request only counts while no alarm owns the slot
    sequence s_ins_req;
        q.errc[LEAC_B_VINS] && pulse_tick && tx_mark && !tx_ais;
    endsequence

    // latch requests: one-second tick or a fresh manual edge
    sequence s_auto_latch;
        q.errc[LEAC_B_CMODE] && sec_tick;
    endsequence

    sequence s_manual_latch;
        !q.errc[LEAC_B_CMODE] && upd_rise;
    endsequence

    // the violation repeats the polarity of the previous mark
    a_violation_insert_done: assert property (
        s_ins_req |=> (tx_line_tip_out == $past(q.last_pol)) &&
                      (tx_line_ring_out == !$past(q.last_pol)))
        else $error("violation not inserted");

    // a write in the same cycle may legally re-arm the bit
    a_violation_clear: assert property (
        s_ins_req ##0 !wr_now |=> !q.errc[LEAC_B_VINS])
        else $error("violation bit not cleared");

    a_rx_alarm_ones: assert property (
        (q.alarm[2] && q.line_los) |=> rx_data_out)
        else $error("rx alarm not ones");

    a_rx_alarm_sys: assert property (
        (q.alarm[3] && system_loss_of_signal) |=> rx_data_out)
        else $error("rx system alarm not ones");

    // without an alarm the received data passes one cycle late
    a_rx_pass: assert property (
        !rx_ais |=> rx_data_out == $past(rx_data_in))
        else $error("rx data not passed");

    a_line_loss_clear: assert property (
        (pulse_tick && !rx_below_thr) |=> !line_loss_of_signal)
        else $error("line loss not cleared");

    a_line_loss_set: assert property (
        (pulse_tick && rx_below_thr && q.lrun + 11'h001 >= n_need)
        |=> line_loss_of_signal)
        else $error("line loss not set");

    // a clear in the same cycle must not hide a new loss
    a_loss_status: assert property (
        (!q.line_los && d.line_los) |=> q.stat[0])
        else $error("line loss status missing");

    a_tx_loss_clear: assert property (
        (pulse_tick && !tx_below_thr) |=> !transmit_loss_of_signal)
        else $error("tx loss not cleared");

    a_tx_loss_set: assert property (
        (pulse_tick && tx_below_thr && q.trun + 7'h01 >= t_need)
        |=> transmit_loss_of_signal)
        else $error("tx loss not set");

    a_tx_window_len: assert property (
        $rose(transmit_loss_of_signal) |-> q.trun == t_need)
        else $error("tx window wrong");

    a_crit_count: assert property (
        $rose(line_loss_of_signal) |-> q.lrun == n_need)
        else $error("line count wrong");

    // a latch restarts the running count and flags the status bit
    a_manual_latch: assert property (
        s_manual_latch |=> q.err_cnt == 16'h0000 && q.stat[4])
        else $error("latch missing");

    a_auto_latch: assert property (
        s_auto_latch |=> q.err_cnt == 16'h0000 && q.stat[4])
        else $error("auto latch missing");

    // a disabled source never moves the count between latches
    a_counter_idle: assert property (
        (csrc == 3'h0 && !sec_tick && !upd_rise) |=> $stable(q.err_cnt))
        else $error("idle counter moved");

    a_bit_error_insert_clear: assert property (
        (pulse_tick && q.eins_pend) |=> !q.eins_pend ##0 pattern_out == !$past(pattern_bit))
        else $error("bit error missing");

    a_eins_clear: assert property (
        (pulse_tick && q.eins_pend && !wr_now) |=> !q.errc[LEAC_B_EINS])
        else $error("error bit not cleared");

    // only the one armed slot is corrupted
    a_pattern_pass: assert property (
        !(pulse_tick && q.eins_pend) |=> pattern_out == $past(pattern_bit))
        else $error("pattern corrupted");

    a_tx_alarm_ones: assert property (
        (pulse_tick && q.alarm[LEAC_B_TRANSMIT_ALARM_FORCE] && !remote_loopback)
        |=> (tx_line_tip_out ^ tx_line_ring_out))
        else $error("tx alarm not ones");

    // in remote loopback the forced alarm gives way to the data
    a_tx_alarm_loop: assert property (
        (pulse_tick && q.alarm[LEAC_B_TRANSMIT_ALARM_FORCE] && remote_loopback && !tx_ais && !tx_mark)
        |=> tx_line_tip_out == $past(tx_data_pos))
        else $error("tx alarm not ignored");
endmodule // leac_core
`default_nettype wire

/* File: leac_pkg.sv */
package leac_pkg;
    // ==========================================================
    // register map (printed offsets are not multiples of four)
    localparam logic [11:0] LEAC_IDX_LOSS   = 12'h00d;
    localparam logic [11:0] LEAC_IDX_ERRC   = 12'h00e;
    localparam logic [11:0] LEAC_IDX_ALARM  = 12'h00f;
    localparam logic [11:0] LEAC_IDX_STAT   = 12'h020;
    localparam logic [11:0] LEAC_IDX_IEN    = 12'h021;
    localparam logic [11:0] LEAC_IDX_ICLR   = 12'h022;
    localparam logic [11:0] LEAC_IDX_CNTH   = 12'h023;
    localparam logic [11:0] LEAC_IDX_CNTL   = 12'h024;
    localparam logic [11:0] LEAC_IDX_LSTAT  = 12'h025;
    localparam logic [7:0]  LEAC_LOSS_RST   = 8'h15;
    localparam logic [7:0]  LEAC_ERRC_RST   = 8'h00;
    localparam logic [7:0]  LEAC_ALARM_RST  = 8'h00;
    // ==========================================================
    // field positions
    localparam int LEAC_B_CRIT   = 7;
    localparam int LEAC_B_EXZDEF = 7;
    localparam int LEAC_B_VINS   = 6;
    localparam int LEAC_B_EINS   = 5;
    localparam int LEAC_B_CSRC   = 2;
    localparam int LEAC_B_CMODE  = 1;
    localparam int LEAC_B_CUPD   = 0;
    localparam int LEAC_B_TRANSMIT_ALARM_FORCE  = 4;
    // ==========================================================
    // loss criteria pulse counts and timing
    localparam int LEAC_N_T1231  = 175;
    localparam int LEAC_N_I431   = 1544;
    localparam int LEAC_TXP_16   = 16;
    localparam int LEAC_TXP_32   = 32;
    localparam int LEAC_TXP_64   = 64;
    localparam int LEAC_CLK_HZ   = 25000000;
    localparam int LEAC_SEC_CYC  = LEAC_CLK_HZ;
    // status bits: 0 line loss, 1 tx loss, 2 violation done, 3 error done, 4 latch
    localparam int LEAC_NEV      = 5;

    typedef struct packed {
        logic [7:0]  loss_cfg;
        logic [7:0]  errc;
        logic [7:0]  alarm;
        logic [4:0]  stat;
        logic [4:0]  ien;
        logic [15:0] err_cnt;
        logic [15:0] err_lat;
        logic [10:0] lrun;
        logic [6:0]  trun;
        logic        line_los;
        logic        tx_los;
        logic        upd_prev;
        logic        eins_prev;
        logic        eins_pend;
        logic [31:0] sec_cnt;
        logic        dph;
        logic        dwr;
        logic [11:0] didx;
        logic        tx_tip;
        logic        tx_ring;
        logic        last_pol;
        logic        rx_data;
        logic        pat_out;
    } leac_state_t;

    typedef struct packed {
        logic        tip;
        logic        ring;
    } leac_tx_t;
endpackage : leac_pkg

/* File: leac_line_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// far side: pulse slots, transmit marks, receive data
module leac_line_model (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // loss levels asked by the bench
    input  wire logic rx_low,
    input  wire logic tx_low,
    // line side
    output logic      pulse_tick,
    output logic      tx_mark,
    output logic      tx_data_pos,
    output logic      tx_data_neg,
    output logic      pattern_bit,
    output logic      rx_data_in,
    output logic      rx_below_thr,
    output logic      tx_below_thr
);
    logic [1:0] div_q;
    logic [3:0] slot_q;
    logic       pol_q;
    // one slot every four clocks; marks on odd slots, polarity alternating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q  <= 2'h0;
            slot_q <= 4'h0;
            pol_q  <= 1'b0;
        end else begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) begin
                slot_q <= slot_q + 4'h1;
                pol_q  <= pol_q ^ slot_q[0];
            end
        end
    end
    // data never sits still, so a stuck output shows at once
    assign pulse_tick   = (div_q == 2'h3);
    assign tx_mark      = slot_q[0];
    assign tx_data_pos  = slot_q[0] & pol_q;
    assign tx_data_neg  = slot_q[0] & ~pol_q;
    assign pattern_bit  = slot_q[0] ^ slot_q[2];
    assign rx_data_in   = slot_q[1];
    assign rx_below_thr = rx_low;
    assign tx_below_thr = tx_low;
endmodule // leac_line_model
`default_nettype wire

/* File: los_error_ais_control_test.sv */
`timescale 1ns/100ps
`default_nettype none
module los_error_ais_control_test;
    import leac_pkg::*;
    // ==========================================================
    // signals
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        rx_low = 1'b0, tx_low = 1'b0, mon = 1'b0, rloop = 1'b0, sloss = 1'b0;
    logic [4:0]  ev = 5'h00;
    wire logic   hready, hresp, irq, tick, mark, dp, dn, pb, rxi, rxb, txb;
    wire logic   tip, ring, pout, rxo, lloss, tloss, exz, tres;
    wire logic [31:0] hrdata;
    wire logic [2:0]  lthr;
    wire logic [1:0]  tthr;
    int          err_total = 0, compares = 0;
    always #20 hclk = ~hclk;
    // ==========================================================
    // design and far side
    leac_core #(.SEC_CYCLES(20)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .irq(irq),
        .pulse_tick(tick), .rx_below_thr(rxb), .tx_below_thr(txb), .monitor_mode(mon),
        .remote_loopback(rloop), .system_loss_of_signal(sloss),
        .line_violation_event(ev[0]), .line_excess_zeros_event(ev[1]),
        .system_violation_event(ev[2]), .system_excess_zeros_event(ev[3]),
        .pattern_error_event(ev[4]), .tx_mark(mark), .tx_data_pos(dp), .tx_data_neg(dn),
        .pattern_bit(pb), .rx_data_in(rxi), .tx_line_tip_out(tip), .tx_line_ring_out(ring),
        .pattern_out(pout), .rx_data_out(rxo), .line_loss_of_signal(lloss),
        .transmit_loss_of_signal(tloss), .line_loss_threshold(lthr),
        .tx_loss_threshold(tthr), .excess_zeros_definition(exz), .threshold_reserved(tres));
    leac_line_model line (.hclk(hclk), .hresetn(hresetn), .rx_low(rx_low), .tx_low(tx_low),
        .pulse_tick(tick), .tx_mark(mark), .tx_data_pos(dp), .tx_data_neg(dn),
        .pattern_bit(pb), .rx_data_in(rxi), .rx_below_thr(rxb), .tx_below_thr(txb));
    // ==========================================================
    // shared tasks
    task automatic results();
        $display("comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // the master assumes no wait count, only the bound stops it
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk("hready", 1, 0);
            results();
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {18'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_ready();
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
        @(posedge hclk);  // the write lands at the data phase edge
    endtask
    task automatic rdc(input logic [11:0] idx, input logic [7:0] exp, input string what);
        bus(1'b0, idx, 8'h00);
        chk(what, {24'h0, exp}, rd);
    endtask
    task automatic ticks(input int n);
        repeat (4 * n) @(posedge hclk);
    endtask
    // eight slots: count all-ones receive slots and transmit slots that carry a mark
    task automatic sample8(output int r, output int t);
        r = 0;
        t = 0;
        ticks(2);
        repeat (8) begin
            ticks(1);
            r += int'(rxo === 1'b1);
            t += int'((tip | ring) === 1'b1);
        end
    endtask
    task automatic poll(input logic [11:0] idx, input int b, input logic v);
        for (int n = 0; n < 40; n++) begin
            bus(1'b0, idx, 8'h00);
            if (rd[b] === v) break;
        end
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        rdc(LEAC_IDX_LOSS, LEAC_LOSS_RST, "loss reset");
        rdc(LEAC_IDX_ERRC, 8'h00, "errc reset");
        rdc(LEAC_IDX_ALARM, 8'h00, "alarm reset");
        chk("line thr", 3'b001, lthr);
        wr(LEAC_IDX_LOSS, 8'hc9);
        rdc(LEAC_IDX_LOSS, 8'hc9, "loss rw");
        chk("line thr", 3'b100, lthr);
        chk("tx thr", 2'b10, tthr);
        chk("reserved", 0, tres);
        mon <= 1'b1;
        ticks(1);
        chk("reserved", 1, tres);
        mon <= 1'b0;
        wr(LEAC_IDX_ERRC, 8'h80);
        chk("excess_zeros_definition", 1, exz);
        wr(LEAC_IDX_ERRC, 8'h00);
        chk("excess_zeros_definition", 0, exz);
        wr(12'h030, 8'hff);
        rdc(12'h030, 8'h00, "unmapped");
        $display("test regs done");
    endtask
    task automatic t_line(input logic c, input int n, input logic [7:0] al);
        int r, t;
        wr(LEAC_IDX_LOSS, {c, 7'h15});
        wr(LEAC_IDX_ICLR, 8'h1f);
        wr(LEAC_IDX_IEN, 8'h01);
        wr(LEAC_IDX_ALARM, al);
        rx_low <= 1'b1;
        ticks(n - 3);
        chk("line loss early", 0, lloss);
        ticks(6);
        chk("line loss", 1, lloss);
        rdc(LEAC_IDX_STAT, 8'h01, "stat");
        chk("irq", 1, irq);
        sample8(r, t);
        chk("rx alarm", al[2], r == 8);
        chk("tx alarm", al[0], t == 8);
        wr(LEAC_IDX_ICLR, 8'h01);
        chk("irq cleared", 0, irq);
        rx_low <= 1'b0;
        ticks(4);
        $display("test line loss done");
    endtask
    task automatic t_tx();
        int p[4] = '{LEAC_TXP_16, LEAC_TXP_32, LEAC_TXP_64, LEAC_TXP_64};
        for (int c = 0; c < 4; c++) begin
            wr(LEAC_IDX_LOSS, 8'h14 | 8'(c));
            tx_low <= 1'b1;
            ticks(p[c] - 3);
            chk("tx loss early", 0, tloss);
            ticks(6);
            chk("tx loss", 1, tloss);
            tx_low <= 1'b0;
            ticks(3);
            chk("tx loss clear", 0, tloss);
        end
        $display("test tx loss done");
    endtask
    task automatic t_count();
        int want[8] = '{0, 1, 1, 2, 1, 1, 2, 1};
        for (int c = 0; c < 8; c++) begin
            wr(LEAC_IDX_ERRC, {3'h0, 3'(c), 2'b00});
            wr(LEAC_IDX_ERRC, {3'h0, 3'(c), 2'b01});
            wr(LEAC_IDX_ERRC, {3'h0, 3'(c), 2'b00});
            for (int k = 0; k < 5; k++) begin
                @(posedge hclk);
                ev <= 5'h01 << k;
                @(posedge hclk);
                ev <= 5'h00;
            end
            wr(LEAC_IDX_ERRC, {3'h0, 3'(c), 2'b01});
            rdc(LEAC_IDX_CNTL, 8'(want[c]), "count low");
            rdc(LEAC_IDX_CNTH, 8'h00, "count high");
        end
        wr(LEAC_IDX_ERRC, 8'h02);
        wr(LEAC_IDX_ICLR, 8'h1f);
        poll(LEAC_IDX_STAT, 4, 1'b1);
        chk("auto latch", 1, rd[4]);
        wr(LEAC_IDX_ERRC, 8'h00);
        $display("test counter done");
    endtask
    task automatic t_insert();
        wr(LEAC_IDX_ICLR, 8'h1f);
        wr(LEAC_IDX_IEN, 8'h0c);
        wr(LEAC_IDX_ERRC, 8'h40);
        poll(LEAC_IDX_ERRC, 6, 1'b0);
        chk("violation bit", 0, rd[6]);
        rdc(LEAC_IDX_STAT, 8'h04, "stat");
        chk("irq", 1, irq);
        wr(LEAC_IDX_ERRC, 8'h20);
        poll(LEAC_IDX_ERRC, 5, 1'b0);
        chk("error bit", 0, rd[5]);
        rdc(LEAC_IDX_STAT, 8'h0c, "stat");
        wr(LEAC_IDX_ICLR, 8'h0c);
        chk("irq cleared", 0, irq);
        $display("test insert done");
    endtask
    task automatic t_alarm();
        int r, t;
        wr(LEAC_IDX_ALARM, 8'h10);
        sample8(r, t);
        chk("forced ones", 1, t == 8);
        rloop <= 1'b1;
        sample8(r, t);
        chk("loopback ignores", 0, t == 8);
        rloop <= 1'b0;
        sloss <= 1'b1;
        wr(LEAC_IDX_ALARM, 8'h0a);
        sample8(r, t);
        chk("rx alarm sys", 1, r == 8);
        chk("tx alarm sys", 1, t == 8);
        sloss <= 1'b0;
        sample8(r, t);
        chk("rx alarm off", 0, r == 8);
        $display("test alarm done");
    endtask
    // ==========================================================
    // main sequence and hang guard
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_line(1'b0, LEAC_N_T1231, 8'h05);
        t_line(1'b1, LEAC_N_I431, 8'h00);
        t_tx();
        t_count();
        t_insert();
        t_alarm();
        results();
    end
    initial begin
        repeat (100000) @(posedge hclk);
        chk("run length", 0, 1);
        results();
    end
endmodule // los_error_ais_control_test
`default_nettype wire
